// >>> src/wdsup_top.sv
`timescale 1ns/1ps
module wdsup_top #(
	parameter int unsigned POWER_ON_DELAY = wdsup_pkg::power_on_delay_clks, // por count
	parameter int unsigned EXP_SHIFT      = 0  // shortens intervals for simulation
) (
	input  wire logic                      clock,         // 40 MHz crystal clock
	input  wire logic                      rst_b,         // synchronous reset, active low
	input  wire logic                      ce,            // clock enable
	input  wire wdsup_pkg::wdsup_sfr_req_t sfr_req,       // sfr read/write request
	output logic [7:0]                     sfr_rdata,     // read data, one cycle later
	output logic                           sfr_hit,       // address owned by block
	input  wire logic                      below_reset,   // supply under reset threshold
	input  wire logic                      below_warning, // supply under warning_threshold
	input  wire logic                      cpu_idle,      // processor sits in idle
	output logic                           cpu_reset,     // reset to processor
	output logic                           dog_irq,       // watchdog interrupt request
	output logic                           pfail_irq,     // power-fail interrupt request
	output logic                           pfail_top_prio,// power-fail overrides others
	output logic [15:0]                    irq_vector,    // vector of the power-fail request, zero otherwise
	output logic                           idle_wake      // leave idle
);
	localparam int CNT_W = 27;
	localparam int POR_W = 17;

	if (EXP_SHIFT > 16 || POWER_ON_DELAY < 1 ||
		POWER_ON_DELAY > wdsup_pkg::power_on_delay_clks) begin : g_bad_param
		$error("wdsup_top: unsupported EXP_SHIFT or POWER_ON_DELAY");
	end

	// register decode helper, used for reads and writes
	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
		return a == b;
	endfunction : addr_is

	// synchronised supply comparators
	logic below_reset_s;
	logic below_warning_s;
	wdsup_sync u_sync_rst (
		.clock   (clock),
		.rst_b   (rst_b),
		.ce      (ce),
		.rst_val (1'b1),
		.din     (below_reset),
		.dout    (below_reset_s)
	);
	wdsup_sync u_sync_warn (
		.clock   (clock),
		.rst_b   (rst_b),
		.ce      (ce),
		.rst_val (1'b0),
		.din     (below_warning),
		.dout    (below_warning_s)
	);

	logic [7:0]                  clk_ctrl_reg;
	logic                        pf_int_en_reg;
	logic                        pf_flag_reg;
	logic                        dog_warn_reg;
	logic                        dog_rst_flag_reg;
	logic                        dog_en_reg;
	logic                        dog_int_en_reg;
	logic [7:0]                  ext_ie_reg;
	wdsup_pkg::wdsup_ta_state_t  ta_reg;
	logic [CNT_W-1:0]            cnt_reg;
	logic [9:0]                  lead_reg;
	logic                        lead_run_reg;
	logic [POR_W-1:0]            por_reg;
	logic                        dog_fire_reg;
	logic                        pf_warn_d_reg;

	logic wr_ta;
	logic wr_sup;
	logic wr_clk_ctrl;
	logic wr_ext_ie;
	logic unlocked;
	logic restart_req;
	logic [CNT_W-1:0] interval_end;
	logic dog_expire;
	logic lead_done;

	assign wr_ta    = sfr_req.wr && addr_is(sfr_req.addr, wdsup_pkg::timed_access_addr);
	assign wr_sup      = sfr_req.wr && addr_is(sfr_req.addr, wdsup_pkg::supervisor_control_addr);
	assign wr_clk_ctrl = sfr_req.wr && addr_is(sfr_req.addr, wdsup_pkg::clock_speed_control_addr);
	assign wr_ext_ie   = sfr_req.wr && addr_is(sfr_req.addr,
		wdsup_pkg::extended_interrupt_enable_addr);
	assign unlocked = (ta_reg == wdsup_pkg::ta_open);
	assign restart_req = wr_sup && unlocked && sfr_req.wdata[wdsup_pkg::pos_dog_restart];

	// timed-access unlock: aa then 55, opens for the very next write only
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ta_reg <= wdsup_pkg::ta_idle;
		end else if (ce && sfr_req.wr) begin
			case (ta_reg)
				wdsup_pkg::ta_idle: begin
					ta_reg <= (wr_ta && sfr_req.wdata == wdsup_pkg::unlock_key_first) ?
						wdsup_pkg::ta_first : wdsup_pkg::ta_idle;
				end
				wdsup_pkg::ta_first: begin
					ta_reg <= (wr_ta && sfr_req.wdata == wdsup_pkg::unlock_key_second) ?
						wdsup_pkg::ta_open : wdsup_pkg::ta_idle;
				end
				wdsup_pkg::ta_open: begin
					ta_reg <= wdsup_pkg::ta_idle; // any write consumes the unlock
				end
				default: begin
					ta_reg <= wdsup_pkg::ta_idle;
				end
			endcase
		end
	end

	// clock control; timeout select in bits 7:6, low bits kept as storage only
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			clk_ctrl_reg <= wdsup_pkg::clock_speed_control_rst;
		end else if (ce && wr_clk_ctrl) begin
			clk_ctrl_reg <= sfr_req.wdata;
		end
	end

	// extended interrupt enable; bit 4 gates the warning interrupt
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ext_ie_reg <= wdsup_pkg::extended_interrupt_enable_rst;
		end else if (ce && wr_ext_ie) begin
			ext_ie_reg <= sfr_req.wdata;
		end
	end
	assign dog_int_en_reg = ext_ie_reg[wdsup_pkg::pos_dog_interrupt_enable];

	// interval end from the two select bits; shift lets tests shrink it
	always_comb begin
		interval_end = '0;
		case ({clk_ctrl_reg[wdsup_pkg::pos_timeout_select_hi],
			clk_ctrl_reg[wdsup_pkg::pos_timeout_select_lo]})
			2'b00:   interval_end[wdsup_pkg::timeout_exp_00 - EXP_SHIFT] = 1'b1;
			2'b01:   interval_end[wdsup_pkg::timeout_exp_01 - EXP_SHIFT] = 1'b1;
			2'b10:   interval_end[wdsup_pkg::timeout_exp_10 - EXP_SHIFT] = 1'b1;
			2'b11:   interval_end[wdsup_pkg::timeout_exp_11 - EXP_SHIFT] = 1'b1;
			default: interval_end[wdsup_pkg::timeout_exp_00 - EXP_SHIFT] = 1'b1;
		endcase
	end
	assign dog_expire = dog_en_reg && !lead_run_reg && (cnt_reg == interval_end - 1'b1);
	assign lead_done  = lead_run_reg &&
		(lead_reg == 10'(wdsup_pkg::warning_lead_clks - 1));

	// supervisor control: protected enable, software-cleared flags
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			dog_en_reg    <= wdsup_pkg::supervisor_control_rst[wdsup_pkg::pos_dog_enable];
			pf_int_en_reg <= wdsup_pkg::supervisor_control_rst[wdsup_pkg::pos_power_fail_int_enable];
		end else if (ce && wr_sup) begin
			pf_int_en_reg <= sfr_req.wdata[wdsup_pkg::pos_power_fail_int_enable];
			if (unlocked) begin
				dog_en_reg <= sfr_req.wdata[wdsup_pkg::pos_dog_enable];
			end
		end
	end

	// flags: hardware set beats a same-cycle software clear
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pf_flag_reg  <= 1'b0;
			dog_warn_reg <= 1'b0;
		end else if (ce) begin
			if (below_warning_s) begin
				pf_flag_reg <= 1'b1;
			end else if (wr_sup && !sfr_req.wdata[wdsup_pkg::pos_power_fail_flag]) begin
				pf_flag_reg <= 1'b0;
			end
			if (dog_expire) begin
				dog_warn_reg <= 1'b1;
			end else if (wr_sup && !sfr_req.wdata[wdsup_pkg::pos_dog_warning]) begin
				dog_warn_reg <= 1'b0;
			end
		end
	end

	// reset-occurred flag survives its own watchdog reset and brownout, cleared only by rst_b or software
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			dog_rst_flag_reg <= 1'b0;
		end else if (ce) begin
			if (lead_done) begin
				dog_rst_flag_reg <= 1'b1;
			end else if (wr_sup && !sfr_req.wdata[wdsup_pkg::pos_dog_reset_occurred]) begin
				dog_rst_flag_reg <= 1'b0;
			end
		end
	end

	// main count and 512-clock lead; restart reloads a full interval
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cnt_reg      <= '0;
			lead_reg     <= '0;
			lead_run_reg <= 1'b0;
		end else if (ce) begin
			if (restart_req || !dog_en_reg || lead_done) begin
				cnt_reg      <= '0;
				lead_reg     <= '0;
				lead_run_reg <= 1'b0;
			end else if (dog_expire) begin
				lead_run_reg <= 1'b1;
			end else if (lead_run_reg) begin
				lead_reg <= lead_reg + 10'h001;
			end else begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end

	// watchdog reset pulse; lead runs regardless of interrupt enable
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			dog_fire_reg <= 1'b0;
		end else if (ce) begin
			dog_fire_reg <= lead_done;
		end
	end

	// power-on delay: hold while supply low, then count before release
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			por_reg <= '0;
		end else if (ce) begin
			if (below_reset_s) begin
				por_reg <= '0;
			end else if (por_reg != POR_W'(POWER_ON_DELAY)) begin
				por_reg <= por_reg + 1'b1;
			end
		end
	end

	// processor reset: por window, brownout, or watchdog fire
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cpu_reset <= 1'b1;
		end else if (ce) begin
			cpu_reset <= below_reset_s || (por_reg != POR_W'(POWER_ON_DELAY)) ||
				dog_fire_reg;
		end
	end

	// interrupt requests, power-fail wins arbitration
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			dog_irq        <= 1'b0;
			pfail_irq      <= 1'b0;
			pfail_top_prio <= 1'b0;
			irq_vector     <= 16'h0000;
			idle_wake      <= 1'b0;
			pf_warn_d_reg  <= 1'b0;
		end else if (ce) begin
			pf_warn_d_reg  <= below_warning_s;
			dog_irq        <= dog_warn_reg && dog_int_en_reg;
			pfail_irq      <= below_warning_s && pf_int_en_reg;
			pfail_top_prio <= below_warning_s && pf_int_en_reg;
			irq_vector     <= (below_warning_s && pf_int_en_reg) ?
				wdsup_pkg::power_fail_vector : 16'h0000;
			idle_wake      <= cpu_idle && dog_warn_reg && dog_int_en_reg;
		end
	end

	// registered read port, unmapped addresses return zero
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			sfr_rdata <= 8'h00;
			sfr_hit   <= 1'b0;
		end else if (ce) begin
			sfr_hit <= sfr_req.rd && (addr_is(sfr_req.addr, wdsup_pkg::supervisor_control_addr) ||
				addr_is(sfr_req.addr, wdsup_pkg::clock_speed_control_addr) ||
				addr_is(sfr_req.addr, wdsup_pkg::extended_interrupt_enable_addr));
			if (sfr_req.rd && addr_is(sfr_req.addr, wdsup_pkg::supervisor_control_addr)) begin
				sfr_rdata <= {2'b00, pf_int_en_reg, pf_flag_reg, dog_warn_reg,
					dog_rst_flag_reg, dog_en_reg, 1'b0}; // restart bit reads zero
			end else if (sfr_req.rd &&
				addr_is(sfr_req.addr, wdsup_pkg::clock_speed_control_addr)) begin
				sfr_rdata <= clk_ctrl_reg;
			end else if (sfr_req.rd &&
				addr_is(sfr_req.addr, wdsup_pkg::extended_interrupt_enable_addr)) begin
				sfr_rdata <= ext_ie_reg;
			end else begin
				sfr_rdata <= 8'h00;
			end
		end
	end

	// restart and enable only move after an unlock
	a_protect_enable: assert property (@(posedge clock) disable iff (!rst_b)
		ce && wr_sup && !unlocked |=> $stable(dog_en_reg))
		else $error("enable changed without unlock");
	// warning flag set, lead phase still running 8 clocks after expiry, then fire sets the reset flag
	sequence s_expire;
		ce && dog_expire && !restart_req;
	endsequence
	a_lead_length: assert property (@(posedge clock) disable iff (!rst_b)
		s_expire ##1 (ce && !restart_req && dog_en_reg)[*8] |-> lead_run_reg)
		else $error("lead phase ended early");
	a_warn_sets: assert property (@(posedge clock) disable iff (!rst_b)
		ce && dog_expire |=> dog_warn_reg)
		else $error("warning flag not set");
	a_fire_flag: assert property (@(posedge clock) disable iff (!rst_b)
		ce && lead_done |=> dog_fire_reg && dog_rst_flag_reg)
		else $error("reset flag missing");
	a_fire_reset: assert property (@(posedge clock) disable iff (!rst_b)
		ce && dog_fire_reg |=> cpu_reset)
		else $error("watchdog did not reset");
	a_brownout_hold: assert property (@(posedge clock) disable iff (!rst_b)
		ce && below_reset_s |=> cpu_reset)
		else $error("reset dropped in brownout");
	a_dog_irq_gate: assert property (@(posedge clock) disable iff (!rst_b)
		dog_irq |-> $past(dog_int_en_reg))
		else $error("warning irq without enable");
	a_pf_sticky: assert property (@(posedge clock) disable iff (!rst_b)
		pf_flag_reg && !(ce && wr_sup) |=> pf_flag_reg)
		else $error("power-fail flag lost");
	a_pf_vector: assert property (@(posedge clock) disable iff (!rst_b)
		pfail_irq |-> irq_vector == wdsup_pkg::power_fail_vector && pfail_top_prio)
		else $error("bad power-fail vector");
	a_restart_zero: assert property (@(posedge clock) disable iff (!rst_b)
		ce && restart_req |=> cnt_reg == '0 && !lead_run_reg)
		else $error("restart did not reload");
endmodule : wdsup_top

// >>> src/wdsup_pkg.sv
package wdsup_pkg;
	// special-function register addresses
	localparam logic [7:0] clock_speed_control_addr       = 8'h8e;
	localparam logic [7:0] supervisor_control_addr        = 8'hd8;
	localparam logic [7:0] extended_interrupt_enable_addr = 8'he8;
	localparam logic [7:0] timed_access_addr              = 8'hc7;
	// unlock key sequence
	localparam logic [7:0] unlock_key_first  = 8'haa;
	localparam logic [7:0] unlock_key_second = 8'h55;
	// supervisor_control field positions
	localparam int pos_dog_restart           = 0;
	localparam int pos_dog_enable            = 1;
	localparam int pos_dog_reset_occurred    = 2;
	localparam int pos_dog_warning           = 3;
	localparam int pos_power_fail_flag       = 4;
	localparam int pos_power_fail_int_enable = 5;
	// clock_speed_control field positions
	localparam int pos_timeout_select_lo = 6;
	localparam int pos_timeout_select_hi = 7;
	// extended_interrupt_enable field position
	localparam int pos_dog_interrupt_enable = 4;
	// reset values
	localparam logic [7:0] clock_speed_control_rst       = 8'h01;
	localparam logic [7:0] supervisor_control_rst        = 8'h00;
	localparam logic [7:0] extended_interrupt_enable_rst = 8'h00;
	// timing in crystal clocks; timeouts as power-of-two exponents
	localparam int timeout_exp_00     = 17;
	localparam int timeout_exp_01     = 20;
	localparam int timeout_exp_10     = 23;
	localparam int timeout_exp_11     = 26;
	localparam int warning_lead_clks  = 512;
	localparam int power_on_delay_clks = 65536;
	localparam logic [15:0] power_fail_vector = 16'h0033;
	// sfr bus request carried as one bundle
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} wdsup_sfr_req_t;
	// unlock tracker states
	typedef enum logic [1:0] {
		ta_idle   = 2'b00,
		ta_first  = 2'b01,
		ta_open   = 2'b10
	} wdsup_ta_state_t;
endpackage : wdsup_pkg

// >>> src/wdsup_sync.sv
`timescale 1ns/1ps
// three-stage input filter: change counts once stages two and three agree
module wdsup_sync (
	input  wire logic clock,   // system clock
	input  wire logic rst_b,   // synchronous reset, active low
	input  wire logic ce,      // clock enable
	input  wire logic rst_val, // value held during reset
	input  wire logic din,     // asynchronous input
	output logic      dout     // filtered level
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// first stage feeds only the second stage
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			s1_reg <= rst_val;
			s2_reg <= rst_val;
			s3_reg <= rst_val;
		end else if (ce) begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// output moves only when the later stages agree, filters one-cycle glitches
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			dout <= rst_val; // preset level; the reset comparator presets 1 and keeps its fault asserted until proven clear
		end else if (ce && (s2_reg == s3_reg)) begin
			dout <= s3_reg;
		end
	end
endmodule : wdsup_sync

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
	localparam int unsigned por_clks  = 16;
	localparam int unsigned exp_shift = 12;
	localparam int          cyc_limit = 60000;

	logic                      clock;
	logic                      rst_b;
	logic                      ce;
	wdsup_pkg::wdsup_sfr_req_t sfr_req;
	logic [7:0]                sfr_rdata;
	logic                      sfr_hit;
	logic                      below_reset;
	logic                      below_warning;
	logic                      cpu_idle;
	logic                      cpu_reset;
	logic                      dog_irq;
	logic                      pfail_irq;
	logic                      pfail_top_prio;
	logic [15:0]               irq_vector;
	logic                      idle_wake;
	int                        n_mismatch;
	int                        check_count;
	int                        cycles;
	int                        n;
	int                        t_int;
	logic [7:0]                rd_val;
	logic                      rd_hit;

	// shortened intervals and power-on count keep the run small
	wdsup_top #(
		.POWER_ON_DELAY(por_clks),
		.EXP_SHIFT     (exp_shift)
	) dut_u (
		.clock         (clock),
		.rst_b         (rst_b),
		.ce            (ce),
		.sfr_req       (sfr_req),
		.sfr_rdata     (sfr_rdata),
		.sfr_hit       (sfr_hit),
		.below_reset   (below_reset),
		.below_warning (below_warning),
		.cpu_idle      (cpu_idle),
		.cpu_reset     (cpu_reset),
		.dog_irq       (dog_irq),
		.pfail_irq     (pfail_irq),
		.pfail_top_prio(pfail_top_prio),
		.irq_vector    (irq_vector),
		.idle_wake     (idle_wake)
	);

	// 40 MHz clock
	always #12.5 clock = ~clock;

	// hang guard: a stuck wait would otherwise never end
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == cyc_limit) begin
			n_mismatch = n_mismatch + 1;
			summarize();
		end
	end

	task automatic summarize();
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count = check_count + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	// inputs change 1 ns after the rising edge
	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : cyc

	// one idle cycle after each request so no strobe is set twice in a step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_req = {1'b1, 1'b0, a, d};
		cyc(1);
		sfr_req = '0;
		cyc(1);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		sfr_req = {1'b0, 1'b1, a, 8'h00};
		cyc(1);
		sfr_req = '0;
		rd_val = sfr_rdata;
		rd_hit = sfr_hit;
		cyc(1);
	endtask : rd

	task automatic unlock_wr(input logic [7:0] d);
		wr(wdsup_pkg::timed_access_addr, wdsup_pkg::unlock_key_first);
		wr(wdsup_pkg::timed_access_addr, wdsup_pkg::unlock_key_second);
		wr(wdsup_pkg::supervisor_control_addr, d);
	endtask : unlock_wr

	// bounded wait on cpu_reset, or on dog_irq when on_irq is set; leaves the cycle count in n
	task automatic count_until(input logic on_irq, input logic lvl, input int cap);
		n = 0;
		while ((on_irq ? dog_irq : cpu_reset) !== lvl && n < cap) begin
			cyc(1);
			n = n + 1;
		end
	endtask : count_until

	initial begin
		clock = 1'b0;
		rst_b = 1'b0;
		ce = 1'b1;
		sfr_req = '0;
		below_reset = 1'b0;
		below_warning = 1'b0;
		cpu_idle = 1'b0;
		n_mismatch = 0;
		check_count = 0;
		cycles = 0;
		cyc(12);
		rst_b = 1'b1;
		// power-on delay before the processor leaves reset
		count_until(1'b0, 1'b0, 200);
		check(n >= por_clks && n <= por_clks + 8, 1);
		rd(wdsup_pkg::clock_speed_control_addr);
		check({rd_hit, rd_val}, {1'b1, wdsup_pkg::clock_speed_control_rst});
		rd(wdsup_pkg::supervisor_control_addr);
		check({rd_hit, rd_val}, {1'b1, wdsup_pkg::supervisor_control_rst});
		rd(wdsup_pkg::extended_interrupt_enable_addr);
		check({rd_hit, rd_val}, {1'b1, wdsup_pkg::extended_interrupt_enable_rst});
		rd(8'h10);
		check({rd_hit, rd_val}, 9'h000);
		// protected writes: plain, broken unlock, then proper unlock
		wr(wdsup_pkg::supervisor_control_addr, 8'h02);
		rd(wdsup_pkg::supervisor_control_addr);
		check(rd_val, 8'h00);
		wr(wdsup_pkg::timed_access_addr, wdsup_pkg::unlock_key_first);
		wr(wdsup_pkg::timed_access_addr, wdsup_pkg::unlock_key_second);
		wr(wdsup_pkg::clock_speed_control_addr, 8'h01);
		wr(wdsup_pkg::supervisor_control_addr, 8'h02);
		rd(wdsup_pkg::supervisor_control_addr);
		check(rd_val, 8'h00);
		unlock_wr(8'h02);
		rd(wdsup_pkg::supervisor_control_addr);
		check(rd_val, 8'h02);
		unlock_wr(8'h00);
		rd(wdsup_pkg::supervisor_control_addr);
		check(rd_val, 8'h00);
		// every select code: interval, warning lead, reset, flags
		wr(wdsup_pkg::extended_interrupt_enable_addr, 8'h10);
		cpu_idle = 1'b1;
		for (int code = 0; code < 4; code++) begin
			wr(wdsup_pkg::clock_speed_control_addr, {code[1:0], 6'h01});
			rd(wdsup_pkg::clock_speed_control_addr);
			check(rd_val, {code[1:0], 6'h01});
			unlock_wr(8'h03);
			t_int = 1 << (17 + 3 * code - exp_shift);
			count_until(1'b1, 1'b1, 20000);
			check(n >= t_int - 2 && n <= t_int + 4, 1);
			cyc(1);
			check(idle_wake, 1'b1);
			count_until(1'b0, 1'b1, 600);
			check(n >= 507 && n <= 514, 1);
			rd(wdsup_pkg::supervisor_control_addr);
			check(rd_val, 8'h0e);
			unlock_wr(8'h00);
			rd(wdsup_pkg::supervisor_control_addr);
			check(rd_val, 8'h00);
		end
		cpu_idle = 1'b0;
		// timely restarts hold the warning off, then a full interval runs
		wr(wdsup_pkg::clock_speed_control_addr, 8'h01);
		unlock_wr(8'h03);
		repeat (6) begin
			cyc(14);
			unlock_wr(8'h03);
			check({dog_irq, cpu_reset}, 2'b00);
		end
		// clock enable low freezes the count, so the interval resumes where it stopped
		ce = 1'b0;
		cyc(50);
		check({dog_irq, cpu_reset}, 2'b00);
		ce = 1'b1;
		count_until(1'b1, 1'b1, 100);
		check(n >= 30 && n <= 36, 1);
		check(idle_wake, 1'b0);
		unlock_wr(8'h00);
		// interrupt masked: still resets, request stays low
		wr(wdsup_pkg::extended_interrupt_enable_addr, 8'h00);
		unlock_wr(8'h02);
		count_until(1'b0, 1'b1, 700);
		check(n >= 32 + 507 && n <= 32 + 516, 1);
		check(dog_irq, 1'b0);
		rd(wdsup_pkg::supervisor_control_addr);
		check(rd_val, 8'h0e);
		unlock_wr(8'h00);
		// power-fail warning with interrupt off, then on
		below_warning = 1'b1;
		cyc(8);
		check(pfail_irq, 1'b0);
		rd(wdsup_pkg::supervisor_control_addr);
		check(rd_val, 8'h10);
		wr(wdsup_pkg::supervisor_control_addr, 8'h30);
		cyc(4);
		check({pfail_irq, pfail_top_prio}, 2'b11);
		check(irq_vector, wdsup_pkg::power_fail_vector);
		below_warning = 1'b0;
		cyc(8);
		check({pfail_irq, pfail_top_prio, irq_vector}, 18'h00000);
		rd(wdsup_pkg::supervisor_control_addr);
		check(rd_val, 8'h30);
		wr(wdsup_pkg::supervisor_control_addr, 8'h20);
		rd(wdsup_pkg::supervisor_control_addr);
		check(rd_val, 8'h20);
		wr(wdsup_pkg::supervisor_control_addr, 8'h00);
		// brown-out: reset held throughout, then power-on delay again
		below_reset = 1'b1;
		cyc(6);
		repeat (30) begin
			check(cpu_reset, 1'b1);
			cyc(1);
		end
		below_reset = 1'b0;
		count_until(1'b0, 1'b0, 200);
		check(n >= por_clks && n <= por_clks + 12, 1);
		summarize();
	end
endmodule : tb
